// File: logic/rtcy_consts.svh
// Offsets, field positions, reset values and timing counts of the RTC
// control block. Assumes inclusion by bare name from logic/.
`ifndef RTCY_CONSTS_SVH
`define RTCY_CONSTS_SVH

// Register indexes on the plain register port
`define RTCY_OFF_CTL2      4'h0
`define RTCY_OFF_CTL3      4'h1
`define RTCY_OFF_YEAR_AL   4'h2

// Second control register fields
`define RTCY_C2_PFLAG      7
`define RTCY_C2_ISEL_HI    6
`define RTCY_C2_ISEL_LO    4
`define RTCY_C2_OSC_EN     3
`define RTCY_C2_ADJUST     2
`define RTCY_C2_DIV_RST    1
`define RTCY_C2_START      0
`define RTCY_C2_RESET_VAL  8'h09

// Third control register fields
`define RTCY_C3_YEAR_EN    7
`define RTCY_C3_RESET_VAL  8'h00

// Seconds rounding threshold, BCD
`define RTCY_ADJ_LAST_DOWN 8'h29

// Crystal edges per 1/256 s step (32768 / 256)
`define RTCY_XTAL_PER_STEP 128

`endif

// File: logic/rtcy_pkg.sv
// Types of the RTC control and year-alarm block.
// Assumes rtcy_consts.svh is on the include path.
package rtcy_pkg;

  typedef enum logic [2:0] {
    RTCY_PER_OFF,
    RTCY_PER_256TH,
    RTCY_PER_64TH,
    RTCY_PER_16TH,
    RTCY_PER_QUARTER,
    RTCY_PER_HALF,
    RTCY_PER_ONE,
    RTCY_PER_TWO
  } rtcy_period_t;

  typedef struct packed {
    logic         pflag;
    rtcy_period_t isel;
    logic         osc_en;
    logic         start;
    logic         year_en;
    logic         xs1;
    logic         xs2;
    logic         xprev;
    logic [6:0]   pre;
    logic [7:0]   cnt64;
    logic         two_s;
    logic [15:0]  rdata;
    logic         irq;
    logic         sec_tick;
    logic         sec_clr;
    logic         min_adv;
    logic         year_match;
  } rtcy_state_t;

endpackage : rtcy_pkg

// File: logic/rtcy_ctrl.sv
// RTC control: periodic flag, divider, start/stop, 30 s adjust, year alarm.
// Assumes a 100 MHz clk, crystal input asynchronous, counters outside.
// How it works
// [R1] Power-on reset loads second control with 09, periodic flag cleared.
// [R2] Manual reset reinits second control except oscillator enable, start.
// [R3] Standby leaves second control register contents unchanged.
// [R4] Periodic flag set by interval or written 1; written 0 clears.
// [R5] Periodic flag at 1 drives the periodic interrupt indication.
// [R6] Periodic request only while interval select nonzero and flag set.
// [R7] Select 1..7 gives 1/256,1/64,1/16,1/4,1/2,1,2 second periods.
// [R8] Oscillator enable 0 halts crystal timebase; power-on value 1.
// [R9] Adjust write: seconds to 00, plus minute advance if 30 or more.
// [R10] Adjust write also resets prescaler and 64 Hz counter.
// [R11] Adjust bit always reads back 0.
// [R12] Divider reset write resets prescaler and 64 Hz counter, self-clears.
// [R13] Start bit 0 freezes second through year counters.
// [R14] Start 0 keeps 64 Hz counter running; only oscillator enable stops it.
// [R15] Year alarm enable 1 compares year counter with year alarm.
// [R16] Year mismatch only when enabled and unequal; disabled counts as match.
// [R17] Software loads year alarm with BCD 0000 to 9999 only.
// [R18] Power-on clears third control; year alarm survives every reset.
// [R19] Third control bits 6..0 read 0 and ignore writes.
// [R20] Year alarm fully read/write, returns last value written.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`include "rtcy_consts.svh"

module rtcy_ctrl (
  // Clock, reset, enable
  input  wire  logic        clk,
  input  wire  logic        rst_b,
  input  wire  logic        clk_en,
  // Chip state
  input  wire  logic        manual_rst,
  input  wire  logic        standby,
  // Crystal, asynchronous
  input  wire  logic        xtal_in,
  // Register port
  input  wire  logic [3:0]  reg_addr,
  input  wire  logic [15:0] reg_wdata,
  input  wire  logic        reg_wr,
  input  wire  logic        reg_rd,
  output logic       [15:0] reg_rdata,
  // Counter side
  input  wire  logic [7:0]  seconds_bcd,
  input  wire  logic [15:0] year_counter,
  output logic              osc_run,
  output logic              counters_run,
  output logic              second_tick,
  output logic              seconds_clear,
  output logic              minute_advance,
  output logic              year_match,
  output logic              periodic_irq_request,
  output logic       [7:0]  sixty_four_hz_counter
);
  import rtcy_pkg::*;

  function automatic logic period_hit(rtcy_period_t sel, logic [7:0] nxt,
                                      logic two);
    unique case (sel)
      RTCY_PER_OFF:     period_hit = 1'b0;
      RTCY_PER_256TH:   period_hit = 1'b1;
      RTCY_PER_64TH:    period_hit = (nxt[1:0] == 2'h0);
      RTCY_PER_16TH:    period_hit = (nxt[3:0] == 4'h0);
      RTCY_PER_QUARTER: period_hit = (nxt[5:0] == 6'h00);
      RTCY_PER_HALF:    period_hit = (nxt[6:0] == 7'h00);
      RTCY_PER_ONE:     period_hit = (nxt == 8'h00);
      RTCY_PER_TWO:     period_hit = (nxt == 8'h00) && two;
    endcase
  endfunction : period_hit

  localparam logic [6:0] PRE_LAST = 7'(`RTCY_XTAL_PER_STEP - 1);

  // Reset release through two flops
  logic rst_s1_q;
  logic rst_sync_b_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q     <= 1'b0;
      rst_sync_b_q <= 1'b0;
    end else begin
      rst_s1_q     <= 1'b1;
      rst_sync_b_q <= rst_s1_q;
    end
  end

  rtcy_state_t s_q;
  rtcy_state_t s_d;
  // No reset on purpose: the alarm value must survive every reset
  logic [15:0] year_alarm_value_q;

  logic       wr_c2;
  logic       wr_c3;
  logic       wr_ya;
  logic       xedge;
  logic       step;
  logic       div_clear;
  logic [7:0] cnt_nxt;
  logic       adj_req;

  assign wr_c2   = reg_wr && (reg_addr == `RTCY_OFF_CTL2);
  assign wr_c3   = reg_wr && (reg_addr == `RTCY_OFF_CTL3);
  assign wr_ya   = reg_wr && (reg_addr == `RTCY_OFF_YEAR_AL);
  assign adj_req = wr_c2 && reg_wdata[`RTCY_C2_ADJUST];
  // Synced crystal rising edge; halted oscillator gives none
  assign xedge   = s_q.xs2 && !s_q.xprev && s_q.osc_en; // [R8]
  assign step    = xedge && (s_q.pre == PRE_LAST);
  assign cnt_nxt = s_q.cnt64 + 8'h01;
  assign div_clear = adj_req ||
                     (wr_c2 && reg_wdata[`RTCY_C2_DIV_RST]); // [R10] [R12]

  always_comb begin
    s_d = s_q;
    s_d.xs1   = xtal_in;
    s_d.xs2   = s_q.xs1;
    s_d.xprev = s_q.xs2;
    s_d.sec_tick = 1'b0;
    s_d.sec_clr  = 1'b0;
    s_d.min_adv  = 1'b0;

    // Timebase runs whatever the start bit says
    if (div_clear) begin
      s_d.pre   = 7'h00; // [R10] [R12]
      s_d.cnt64 = 8'h00;
      s_d.two_s = 1'b0;
    end else if (xedge) begin // [R14]
      s_d.pre = s_q.pre + 7'h01;
      if (step) begin
        s_d.cnt64 = cnt_nxt;
        if (cnt_nxt == 8'h00) begin
          s_d.two_s    = !s_q.two_s;
          s_d.sec_tick = s_q.start; // [R13]
        end
      end
    end

    // Register writes; the divider reset bit is never stored
    if (wr_c2) begin
      s_d.pflag  = reg_wdata[`RTCY_C2_PFLAG]; // [R4]
      s_d.isel   = rtcy_period_t'(
                     reg_wdata[`RTCY_C2_ISEL_HI:`RTCY_C2_ISEL_LO]);
      s_d.osc_en = reg_wdata[`RTCY_C2_OSC_EN]; // [R8]
      s_d.start  = reg_wdata[`RTCY_C2_START]; // [R13]
    end
    if (wr_c3) begin
      s_d.year_en = reg_wdata[`RTCY_C3_YEAR_EN]; // [R19]
    end

    // Rounding uses BCD seconds as they stand
    if (adj_req) begin
      s_d.sec_clr = 1'b1; // [R9]
      s_d.min_adv = (seconds_bcd > `RTCY_ADJ_LAST_DOWN); // [R9]
    end

    // Interval event beats a same-cycle clear
    if (!div_clear && step && period_hit(s_q.isel, cnt_nxt, s_q.two_s)) begin
      s_d.pflag = 1'b1; // [R4] [R7]
    end

    // Manual reset spares oscillator enable and start; standby spares all
    if (manual_rst && !standby) begin // [R3]
      s_d.pflag = 1'b0; // [R2]
      s_d.isel  = RTCY_PER_OFF;
    end

    s_d.irq = s_d.pflag && (s_d.isel != RTCY_PER_OFF); // [R5] [R6]
    s_d.year_match = !s_d.year_en ||
                     (year_counter == year_alarm_value_q); // [R15] [R16]

    s_d.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `RTCY_OFF_CTL2: s_d.rdata = {8'h00, s_q.pflag, s_q.isel, s_q.osc_en,
                                     1'b0, 1'b0, s_q.start}; // [R11]
        `RTCY_OFF_CTL3: s_d.rdata = {8'h00, s_q.year_en, 7'h00}; // [R19]
        `RTCY_OFF_YEAR_AL: s_d.rdata = year_alarm_value_q; // [R20]
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      s_q <= '{pflag: 1'b0,
               isel: rtcy_period_t'(
                       3'(`RTCY_C2_RESET_VAL >> `RTCY_C2_ISEL_LO)),
               osc_en: 1'(`RTCY_C2_RESET_VAL >> `RTCY_C2_OSC_EN),
               start: 1'(`RTCY_C2_RESET_VAL >> `RTCY_C2_START),
               year_en: 1'(`RTCY_C3_RESET_VAL >> `RTCY_C3_YEAR_EN),
               year_match: 1'b1,
               default: '0}; // [R1] [R18]
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en && wr_ya) begin
      year_alarm_value_q <= reg_wdata; // [R18] [R20]
    end
  end

  assign reg_rdata             = s_q.rdata;
  assign osc_run               = s_q.osc_en;
  assign counters_run          = s_q.start;
  assign second_tick           = s_q.sec_tick;
  assign seconds_clear         = s_q.sec_clr;
  assign minute_advance        = s_q.min_adv;
  assign year_match            = s_q.year_match;
  assign periodic_irq_request  = s_q.irq;
  assign sixty_four_hz_counter = s_q.cnt64;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b_q);

  irq_needs_sel_a: assert property ( // [R6]
    periodic_irq_request |-> (s_q.pflag && s_q.isel != RTCY_PER_OFF))
    else $error("periodic request without flag and select");

  irq_follows_flag_a: assert property ( // [R5]
    clk_en && s_q.pflag && s_q.isel != RTCY_PER_OFF && !wr_c2 && !manual_rst
    |=> periodic_irq_request)
    else $error("periodic flag set but no request");

  flag_write_a: assert property ( // [R4]
    clk_en && wr_c2 && !manual_rst && reg_wdata[`RTCY_C2_PFLAG]
    |=> s_q.pflag)
    else $error("writing one did not set periodic flag");

  flag_event_a: assert property ( // [R4]
    clk_en && step && !div_clear && s_q.isel == RTCY_PER_256TH && !manual_rst
    |=> s_q.pflag)
    else $error("interval event lost");

  adj_reads_zero_a: assert property ( // [R11]
    reg_rdata[`RTCY_C2_ADJUST] == 1'b0 && reg_rdata[`RTCY_C2_DIV_RST] == 1'b0)
    else $error("adjust or divider bit read as one");

  adj_round_a: assert property ( // [R9]
    clk_en && adj_req && seconds_bcd >= 8'h30
    |=> seconds_clear && minute_advance)
    else $error("adjust did not round up");

  adj_down_a: assert property ( // [R9]
    clk_en && adj_req && seconds_bcd <= 8'h29
    |=> seconds_clear && !minute_advance)
    else $error("adjust did not round down");

  div_reset_a: assert property ( // [R10]
    clk_en && div_clear
    |=> sixty_four_hz_counter == 8'h00 && s_q.pre == 7'h00)
    else $error("divider not reset");

  osc_stop_a: assert property ( // [R8]
    clk_en && !s_q.osc_en && !div_clear |=> $stable(sixty_four_hz_counter))
    else $error("64 Hz counter moved with oscillator halted");

  start_gate_a: assert property ( // [R13]
    second_tick |-> $past(s_q.start))
    else $error("second tick while counters stopped");

  manual_keep_a: assert property ( // [R2]
    clk_en && manual_rst && !standby && !wr_c2
    |=> $stable(s_q.osc_en) && $stable(s_q.start) && s_q.isel == RTCY_PER_OFF)
    else $error("manual reset mishandled");

  year_cmp_a: assert property ( // [R16]
    clk_en && s_q.year_en && !wr_c3 && year_counter != year_alarm_value_q
    |=> !year_match)
    else $error("year match while unequal");

  ctl3_zero_a: assert property ( // [R19]
    $past(reg_rd) && $past(reg_addr) == `RTCY_OFF_CTL3
    |-> reg_rdata[6:0] == 7'h00)
    else $error("third control low bits not zero");

  flag_clear_a: assert property ( // [R4]
    clk_en && wr_c2 && !reg_wdata[`RTCY_C2_PFLAG] && !step
    |=> !s_q.pflag)
    else $error("writing zero did not clear periodic flag");

  sel_write_a: assert property ( // [R7]
    clk_en && wr_c2 && !manual_rst
    |=> s_q.isel == $past(reg_wdata[`RTCY_C2_ISEL_HI:`RTCY_C2_ISEL_LO]))
    else $error("interval select not stored");

  osc_write_a: assert property ( // [R8]
    clk_en && wr_c2 |=> osc_run == $past(reg_wdata[`RTCY_C2_OSC_EN]))
    else $error("oscillator enable not stored");

  start_write_a: assert property ( // [R13]
    clk_en && wr_c2 |=> counters_run == $past(reg_wdata[`RTCY_C2_START]))
    else $error("start bit not stored");

  no_event_off_a: assert property ( // [R7]
    clk_en && s_q.isel == RTCY_PER_OFF && !wr_c2 && !s_q.pflag
    |=> !s_q.pflag)
    else $error("periodic flag set with select off");

  standby_keep_a: assert property ( // [R3]
    clk_en && standby && !reg_wr
    |=> $stable(s_q.isel) && $stable(s_q.osc_en) && $stable(s_q.start))
    else $error("standby changed second control");

  ctl3_keep_a: assert property ( // [R18]
    clk_en && !wr_c3 |=> $stable(s_q.year_en))
    else $error("year enable changed without a write");

  tick_at_wrap_a: assert property ( // [R13]
    second_tick |-> sixty_four_hz_counter == 8'h00)
    else $error("second tick away from counter wrap");

  clr_pulse_a: assert property ( // [R9]
    seconds_clear && !(clk_en && adj_req) |=> !seconds_clear)
    else $error("seconds clear longer than one cycle");

  adv_with_clr_a: assert property ( // [R9]
    minute_advance |-> seconds_clear)
    else $error("minute advance without seconds clear");

  cnt_step_a: assert property ( // [R14]
    clk_en && step && !div_clear
    |=> sixty_four_hz_counter == $past(sixty_four_hz_counter) + 8'h01)
    else $error("64 Hz counter missed a step");

  cnt_hold_a: assert property ( // [R14]
    clk_en && !step && !div_clear |=> $stable(sixty_four_hz_counter))
    else $error("64 Hz counter moved without a step");

  irq_low_a: assert property ( // [R6]
    s_q.isel == RTCY_PER_OFF |-> !periodic_irq_request)
    else $error("periodic request with select off");

  year_off_a: assert property ( // [R16]
    !s_q.year_en |-> year_match)
    else $error("disabled year alarm blocks match");

  year_eq_a: assert property ( // [R15]
    clk_en && s_q.year_en && !wr_c3 && year_counter == year_alarm_value_q
    |=> year_match)
    else $error("equal year not matched");

  osc_halt_pre_a: assert property ( // [R8]
    clk_en && !s_q.osc_en && !div_clear |=> $stable(s_q.pre))
    else $error("prescaler moved with oscillator halted");

  manual_flag_a: assert property ( // [R2]
    clk_en && manual_rst && !standby
    |=> !s_q.pflag && !periodic_irq_request)
    else $error("manual reset left periodic flag set");

  rd_idle_a: assert property ( // [R20]
    $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");

  ya_readback_a: assert property ( // [R20]
    clk_en && wr_ya ##1 clk_en && reg_rd && reg_addr == `RTCY_OFF_YEAR_AL
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("year alarm readback differs");

  cov_irq_c: cover property (periodic_irq_request);
  cov_round_c: cover property (minute_advance);
  cov_down_c: cover property (seconds_clear && !minute_advance);
  cov_year_c: cover property (s_q.year_en && year_match);
  cov_two_c: cover property (step && s_q.isel == RTCY_PER_TWO && s_d.pflag);

endmodule : rtcy_ctrl

// File: dv/rtcy_bench.sv
// Self-checking bench for the RTC control and year-alarm block.
// Assumes rtcy_ctrl; crystal sped up to 8 clk a cycle to keep runs short.
module rtc_control_and_year_alarm_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, manual_rst, standby, reg_wr, reg_rd;
  logic        osc_run, counters_run, seconds_clear, minute_advance;
  logic        year_match, irq, tick;
  int          tick_n = 0;
  int          ticks_at;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, year_counter, d;
  logic [7:0]  seconds_bcd, cnt64, snap;
  logic [2:0]  xc;
  int          bad_count, cmp_count;

  rtcy_ctrl dut (
    .clk(clk), .rst_b(rst_b), .clk_en(1'b1), .manual_rst(manual_rst),
    .standby(standby), .xtal_in(xc[2]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .seconds_bcd(seconds_bcd),
    .year_counter(year_counter), .osc_run(osc_run),
    .counters_run(counters_run), .second_tick(tick),
    .seconds_clear(seconds_clear), .minute_advance(minute_advance),
    .year_match(year_match), .periodic_irq_request(irq),
    .sixty_four_hz_counter(cnt64));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Free-running crystal stand-in
  always @(posedge clk) xc <= xc + 3'h1;
  always @(posedge clk) if (tick === 1'b1) tick_n++;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic t_reset;
    rd(4'h0); chk(d, 16'h0009);
    rd(4'h1); chk(d, 16'h0000);
    chk(osc_run, 1'b1);
    chk(counters_run, 1'b1);
  endtask : t_reset

  task automatic t_year;
    wr(4'h2, 16'h1999);
    wr(4'h1, 16'h0080);
    rd(4'h1); chk(d, 16'h0080);
    rd(4'h2); chk(d, 16'h1999);
    @(posedge clk);
    year_counter <= 16'h2000;
    repeat (2) @(posedge clk);
    #1 chk(year_match, 1'b0);
    @(posedge clk);
    year_counter <= 16'h1999;
    repeat (2) @(posedge clk);
    #1 chk(year_match, 1'b1);
    @(posedge clk);
    year_counter <= 16'h2000;
    wr(4'h1, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk(year_match, 1'b1);
  endtask : t_year

  task automatic t_flag;
    wr(4'h0, 16'h0089);
    rd(4'h0); chk(d, 16'h0089);
    chk(irq, 1'b0);
    wr(4'h0, 16'h00F9);
    #1 chk(irq, 1'b1);
    wr(4'h0, 16'h0079);
    #1 chk(irq, 1'b0);
    wr(4'h0, 16'h0009);
  endtask : t_flag

  // Seconds rounding; also restarts the divider
  task automatic t_adj(input logic [7:0] s, input logic adv);
    @(posedge clk);
    seconds_bcd <= s;
    wr(4'h0, 16'h000D);
    #1 chk(seconds_clear, 1'b1);
    chk(minute_advance, adv);
    chk(cnt64, 8'h00);
    rd(4'h0); chk(d, 16'h0009);
  endtask : t_adj

  task automatic t_div;
    repeat (300) @(posedge clk);
    wr(4'h0, 16'h000B);
    #1 chk(cnt64, 8'h00);
    rd(4'h0); chk(d, 16'h0009);
  endtask : t_div

  task automatic t_start;
    wr(4'h0, 16'h0008);
    #1 chk(counters_run, 1'b0);
    snap = cnt64;
    ticks_at = tick_n;
    repeat (1100) @(posedge clk);
    #1 chk(cnt64 == snap, 1'b0);
    chk(16'(tick_n - ticks_at), 16'h0000);
    wr(4'h0, 16'h0000);
    #1 chk(osc_run, 1'b0);
    repeat (4) @(posedge clk);
    #1 snap = cnt64;
    repeat (1100) @(posedge clk);
    #1 chk(cnt64 == snap, 1'b1);
    wr(4'h0, 16'h0009);
  endtask : t_start

  // Step of 128 crystal edges at 8 clk each after a divider restart
  task automatic t_period;
    wr(4'h0, 16'h001B);
    repeat (900) @(posedge clk);
    #1 chk(irq, 1'b0);
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
    #1 chk(irq, 1'b1);
    rd(4'h0); chk(d, 16'h0099);
    wr(4'h0, 16'h0009);
  endtask : t_period

  task automatic t_manual;
    wr(4'h0, 16'h00C8);
    @(posedge clk);
    standby    <= 1'b1;
    manual_rst <= 1'b1;
    @(posedge clk);
    manual_rst <= 1'b0;
    rd(4'h0); chk(d, 16'h00C8);
    @(posedge clk);
    standby    <= 1'b0;
    manual_rst <= 1'b1;
    @(posedge clk);
    manual_rst <= 1'b0;
    rd(4'h0); chk(d, 16'h0008);
    chk(irq, 1'b0);
  endtask : t_manual

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // Whole run is about 3600 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial begin
    rst_b = 1'b0;
    manual_rst = 1'b0;
    standby = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    seconds_bcd = 8'h00;
    year_counter = 16'h0000;
    xc = 3'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_year();
    t_flag();
    t_adj(8'h30, 1'b1);
    t_adj(8'h29, 1'b0);
    t_div();
    t_start();
    t_period();
    t_manual();
    close_out();
  end
endmodule : rtc_control_and_year_alarm_bench
